// ### flash_dev_model.sv
// Behavioural flash device model driven from the host pins
`timescale 1ns/1ps
module flash_dev_model
    import flash_host_pkg::*;
(
    input  wire flash_host_pkg::flash_pins_s          pins_in,
    output logic [flash_host_pkg::FLASH_DW-1:0] dq_out,
    output logic                                ready_busy_out
);
    logic [FLASH_DW-1:0] cell_ff = 16'hffff;
    logic [FLASH_DW-1:0] last_ff = 16'h0000;
    logic [FLASH_DW-1:0] prev_ff = 16'h0000;
    int                  wr_count = 0;
    initial ready_busy_out = 1'b1;
    // Released bus shows the inverse so a stale value never passes
    assign dq_out = (!pins_in.ce_n && !pins_in.oe_n) ? cell_ff : ~last_ff;
    always @(posedge pins_in.we_n) begin
        if (!pins_in.ce_n && pins_in.rst_n) begin
            wr_count++;
            // Busy figure is arbitrary; long enough to see an abort
            if (ready_busy_out && (prev_ff == CODE_PROG || pins_in.dq == CODE_CHIP)) begin
                cell_ff = (prev_ff == CODE_PROG) ? (cell_ff & pins_in.dq) : 16'hffff;
                ready_busy_out <= 1'b0;
                ready_busy_out <= #3000 1'b1;
            end
            prev_ff = ready_busy_out ? pins_in.dq : 16'h0000;
            last_ff = pins_in.dq;
        end
    end
    always @(negedge pins_in.rst_n) ready_busy_out <= 1'b1;
endmodule // flash_dev_model

// ### flash_host.sv
// Avalon-MM controlled host that issues command sequences to a parallel NOR flash
//
// Overview of operation
// - Enter secure region with three writes; host then tracks secure mode.
// - Secure region stays selected until the four-write exit sequence is sent or a hardware reset is issued.
// - Standard program is two unlocks, setup code, then target address and data.
// - Hardware reset pin aborts programming; host repeats sequence afterwards (flash_host itself does not reissue it).
// - Bypass entry is two unlocks followed by code 20h.
// - Bypass program is A0h then address and data, repeatable.
// - Bypass exit writes 90h then F0h; addresses do not matter.
// - Chip erase is two unlocks, setup, two unlocks, chip erase code.
// - No commands during chip erase (host still accepts suspend while busy); hardware reset aborts, host reissues (flash_host does not).
// - Sector erase is two unlocks, setup, two unlocks, sector address plus code.
// - 50 us window from last strobe rise accepts further sector writes.
// - Any other write in the window ends it and returns device to read.
// - Once sector erase runs, only suspend is issued; reset aborts it.
`timescale 1ns/1ps
module flash_host
    import flash_host_pkg::*;
#(
    parameter logic [FLASH_DW-1:0] SECTOR_CODE  = 16'h0030,
    parameter logic [FLASH_DW-1:0] SUSPEND_CODE = 16'h00b0
) (
    input  wire logic                         clk_in,
    input  wire logic                         srst_in,
    input  wire logic [4:0]                   avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [31:0]                  avs_writedata_in,
    output logic      [31:0]                  avs_readdata_out,
    output logic                              avs_waitrequest_out,
    output flash_host_pkg::flash_pins_s       flash_pins_out,
    input  wire logic [flash_host_pkg::FLASH_DW-1:0] flash_dq_in,
    input  wire logic                         ready_busy_in
);
    import flash_host_pkg::*;

    typedef struct packed {
        seq_e                st;
        logic [2:0]          step;
        logic [15:0]         cnt;
        cmd_e                cmd;
        logic [FLASH_AW-1:0] reg_addr;
        logic [FLASH_DW-1:0] reg_data;
        logic                byte_mode;
        logic                bypass;
        logic                secure;
        logic                win_open;
        logic [15:0]         win_cnt;
        logic                refused;
        logic [FLASH_DW-1:0] rdata;
        logic                toggled;
        logic                rvalid;
        logic [31:0]         readdata;
        flash_pins_s         pins;
    } state_s;

    state_s state_ff;
    state_s nxt_state;

    logic       cmd_wr;
    logic       last_step;
    step_s      cur_step;
    step_s      first_step;
    cmd_e       new_cmd;

    // Address and data of step i of a command sequence
    function automatic step_s seq_step(input cmd_e c, input logic [2:0] i,
                                       input logic [FLASH_AW-1:0] a,
                                       input logic [FLASH_DW-1:0] d);
        step_s r;
        r = '{addr: UNLOCK_A1, data: UNLOCK_D1, last: 1'b0};
        if (i == 3'd1 || i == 3'd4) begin
            r.addr = UNLOCK_A2;
            r.data = UNLOCK_D2;
        end
        case (c)
            CMD_PROGRAM: begin
                if (i == 3'd2) r.data = CODE_PROG;
                if (i == 3'd3) r = '{addr: a, data: d, last: 1'b1};
            end
            CMD_BYP_ENTER: begin
                if (i == 3'd2) r = '{addr: UNLOCK_A1, data: CODE_BYP, last: 1'b1};
            end
            CMD_BYP_PROGRAM: begin
                r = (i == 3'd0) ? '{addr: UNLOCK_A1, data: CODE_PROG, last: 1'b0}
                                : '{addr: a, data: d, last: 1'b1};
            end
            CMD_BYP_EXIT: begin
                r = (i == 3'd0) ? '{addr: UNLOCK_A1, data: CODE_X90, last: 1'b0}
                                : '{addr: UNLOCK_A1, data: CODE_RESET, last: 1'b1};
            end
            CMD_CHIP_ERASE, CMD_SECTOR_ERASE: begin
                if (i == 3'd2) r.data = CODE_ERASE;
                if (i == 3'd5) begin
                    r = (c == CMD_CHIP_ERASE) ? '{addr: UNLOCK_A1, data: CODE_CHIP, last: 1'b1}
                                              : '{addr: a, data: SECTOR_CODE, last: 1'b1};
                end
            end
            CMD_SECTOR_ADD:   r = '{addr: a, data: SECTOR_CODE, last: 1'b1};
            CMD_SUSPEND:      r = '{addr: UNLOCK_A1, data: SUSPEND_CODE, last: 1'b1};
            CMD_RESET:        r = '{addr: UNLOCK_A1, data: CODE_RESET, last: 1'b1};
            CMD_SECURE_ENTER: begin
                if (i == 3'd2) r = '{addr: UNLOCK_A1, data: CODE_SEC_IN, last: 1'b1};
            end
            CMD_SECURE_EXIT: begin
                if (i == 3'd2) r.data = CODE_X90;
                if (i == 3'd3) r = '{addr: UNLOCK_A1, data: CODE_SEC_OUT, last: 1'b1};
            end
            default: r.last = 1'b1;
        endcase
        return r;
    endfunction

    // Whether a command may be issued in the present mode
    function automatic logic cmd_allowed(input cmd_e c, input state_s s, input logic rdy);
        logic ok;
        ok = 1'b1;
        if (s.bypass) begin
            ok = (c == CMD_BYP_PROGRAM) || (c == CMD_BYP_EXIT) ||
                 (c == CMD_READ) || (c == CMD_HW_RESET);
        end else if (c == CMD_BYP_PROGRAM || c == CMD_BYP_EXIT) begin
            ok = 1'b0;
        end
        if (c == CMD_BYP_ENTER && s.secure) ok = 1'b0;
        // Late sector writes might miss the window and be dropped silently
        if (c == CMD_SECTOR_ADD && !(s.win_open && s.win_cnt + ADD_SPAN_CYC < WINDOW_CYC))
            ok = 1'b0;
        // Device is running an algorithm; it would ignore anything but suspend
        if (!rdy && !s.win_open && c != CMD_READ && c != CMD_SUSPEND && c != CMD_HW_RESET)
            ok = 1'b0;
        if (c == CMD_NONE || c > CMD_HW_RESET) ok = 1'b0;
        return ok;
    endfunction

    assign cmd_wr              = avs_write_in && avs_address_in == OFS_CMD;
    // Command writes stall until the previous sequence has left the pins
    assign avs_waitrequest_out = (avs_read_in && !state_ff.rvalid) ||
                                 (cmd_wr && state_ff.st != ST_IDLE);
    assign avs_readdata_out    = state_ff.readdata;
    assign flash_pins_out      = state_ff.pins;
    assign new_cmd             = cmd_e'(avs_writedata_in[3:0]);
    assign cur_step  = seq_step(state_ff.cmd, state_ff.step, state_ff.reg_addr,
                                state_ff.reg_data);
    assign first_step = seq_step(new_cmd, 3'd0, state_ff.reg_addr, state_ff.reg_data);
    assign last_step = cur_step.last;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = avs_read_in && !state_ff.rvalid;
        if (avs_read_in && !state_ff.rvalid) begin
            case (avs_address_in)
                OFS_ADDR:   nxt_state.readdata = 32'(state_ff.reg_addr);
                OFS_DATA:   nxt_state.readdata = 32'(state_ff.reg_data);
                OFS_CTRL:   nxt_state.readdata = 32'(state_ff.byte_mode);
                OFS_STATUS: nxt_state.readdata = 32'({state_ff.toggled, state_ff.refused,
                                                      state_ff.win_open, state_ff.secure,
                                                      state_ff.bypass, ready_busy_in,
                                                      state_ff.st != ST_IDLE});
                OFS_RDATA:  nxt_state.readdata = 32'(state_ff.rdata);
                default:    nxt_state.readdata = 32'h0000_0000;
            endcase
        end
        if (avs_write_in) begin
            case (avs_address_in)
                OFS_ADDR:   nxt_state.reg_addr  = avs_writedata_in[FLASH_AW-1:0];
                OFS_DATA:   nxt_state.reg_data  = avs_writedata_in[FLASH_DW-1:0];
                OFS_CTRL:   nxt_state.byte_mode = avs_writedata_in[CTRL_BYTE_BIT];
                OFS_STATUS: begin
                    if (avs_writedata_in[ST_REFUSED_BIT]) nxt_state.refused = 1'b0;
                end
                default: ;
            endcase
        end
        nxt_state.pins.byte_n = !state_ff.byte_mode;

        // Acceptance window timer from the rising strobe edge
        if (state_ff.win_open) begin
            nxt_state.win_cnt = state_ff.win_cnt + 16'h0001;
            if (state_ff.win_cnt == WINDOW_CYC - 16'h0001) nxt_state.win_open = 1'b0;
        end

        case (state_ff.st)
            ST_IDLE: begin
                if (cmd_wr) begin
                    if (!cmd_allowed(new_cmd, state_ff, ready_busy_in)) begin
                        nxt_state.refused = 1'b1;
                    end else begin
                        nxt_state.cmd  = new_cmd;
                        nxt_state.step = 3'd0;
                        nxt_state.cnt  = 16'h0000;
                        if (new_cmd != CMD_READ && new_cmd != CMD_SECTOR_ADD)
                            nxt_state.win_open = 1'b0;
                        if (new_cmd == CMD_READ) begin
                            nxt_state.st        = ST_RD;
                            nxt_state.pins.addr = state_ff.reg_addr;
                            nxt_state.pins.ce_n = 1'b0;
                            nxt_state.pins.oe_n = 1'b0;
                        end else if (new_cmd == CMD_HW_RESET) begin
                            nxt_state.st         = ST_RST;
                            nxt_state.pins.rst_n = 1'b0;
                            nxt_state.bypass     = 1'b0;
                            nxt_state.secure     = 1'b0;
                        end else begin
                            nxt_state.st         = ST_WR_SETUP;
                            nxt_state.pins.addr  = first_step.addr;
                            nxt_state.pins.dq    = first_step.data;
                            nxt_state.pins.dq_oe = 1'b1;
                            nxt_state.pins.ce_n  = 1'b0;
                        end
                    end
                end
            end
            ST_WR_SETUP: begin
                nxt_state.pins.we_n = 1'b0;
                nxt_state.st        = ST_WR_LOW;
                nxt_state.cnt       = 16'h0000;
            end
            ST_WR_LOW: begin
                nxt_state.cnt = state_ff.cnt + 16'h0001;
                if (state_ff.cnt == WE_LOW_CYC - 16'h0001) begin
                    nxt_state.pins.we_n = 1'b1;
                    nxt_state.st        = ST_WR_HIGH;
                    if (last_step && (state_ff.cmd == CMD_SECTOR_ERASE ||
                                      state_ff.cmd == CMD_SECTOR_ADD)) begin
                        nxt_state.win_open = 1'b1;
                        nxt_state.win_cnt  = 16'h0000;
                    end
                end
            end
            ST_WR_HIGH: begin
                if (last_step) begin
                    nxt_state.st         = ST_IDLE;
                    nxt_state.pins.ce_n  = 1'b1;
                    nxt_state.pins.dq_oe = 1'b0;
                    case (state_ff.cmd)
                        CMD_BYP_ENTER:    nxt_state.bypass = 1'b1;
                        CMD_BYP_EXIT:     nxt_state.bypass = 1'b0;
                        CMD_SECURE_ENTER: nxt_state.secure = 1'b1;
                        CMD_SECURE_EXIT:  nxt_state.secure = 1'b0;
                        default: ;
                    endcase
                end else begin
                    nxt_state.step      = state_ff.step + 3'd1;
                    nxt_state.st        = ST_WR_SETUP;
                    nxt_state.pins.addr = seq_step(state_ff.cmd, state_ff.step + 3'd1,
                                                   state_ff.reg_addr, state_ff.reg_data).addr;
                    nxt_state.pins.dq   = seq_step(state_ff.cmd, state_ff.step + 3'd1,
                                                   state_ff.reg_addr, state_ff.reg_data).data;
                end
                // Upper byte is left at zero in byte mode
                if (state_ff.byte_mode)
                    nxt_state.pins.dq[FLASH_DW-1:8] = 8'h00;
            end
            ST_RD: begin
                nxt_state.cnt = state_ff.cnt + 16'h0001;
                if (state_ff.cnt == READ_CYC - 16'h0001) begin
                    // Status polling: a flipping toggle bit means the algorithm still runs
                    nxt_state.rdata   = flash_dq_in;
                    nxt_state.toggled = flash_dq_in[TOGGLE_BIT] ^ state_ff.rdata[TOGGLE_BIT];
                    nxt_state.pins.ce_n = 1'b1;
                    nxt_state.pins.oe_n = 1'b1;
                    nxt_state.st        = ST_IDLE;
                end
            end
            ST_RST: begin
                nxt_state.cnt = state_ff.cnt + 16'h0001;
                if (state_ff.cnt == RST_LOW_CYC - 16'h0001) nxt_state.pins.rst_n = 1'b1;
                if (state_ff.cnt == RST_ALL_CYC - 16'h0001) nxt_state.st = ST_IDLE;
            end
            default: nxt_state.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_ff          <= '0;
            state_ff.st       <= ST_IDLE;
            state_ff.cmd      <= CMD_NONE;
            state_ff.reg_data <= RST_DATA;
            state_ff.readdata <= RST_RDAT;
            state_ff.pins     <= '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                                   oe_n: 1'b1, rst_n: 1'b1, byte_n: 1'b1};
        end else begin
            state_ff <= nxt_state;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    AST_WE_NEEDS_CE: assert property (!flash_pins_out.we_n |-> !flash_pins_out.ce_n)
        else $error("write strobe low without chip select");
    AST_NO_DRIVE_FIGHT: assert property (flash_pins_out.dq_oe |-> flash_pins_out.oe_n)
        else $error("data driven while flash output enabled");
    AST_WE_WIDTH: assert property ($fell(flash_pins_out.we_n) |->
                                   !flash_pins_out.we_n [*2] ##1 flash_pins_out.we_n)
        else $error("write strobe width wrong");
    AST_BYP_NOT_SECURE: assert property (!(state_ff.bypass && state_ff.secure))
        else $error("bypass mode while secure region selected");
    AST_WINDOW_LIMIT: assert property (state_ff.win_open |-> state_ff.win_cnt < WINDOW_CYC)
        else $error("acceptance window overran");
    AST_RST_PULSE: assert property ($fell(flash_pins_out.rst_n) |->
                                    !flash_pins_out.rst_n [*8])
        else $error("hardware reset pulse too short");
    AST_NO_CMD_BUSY: assert property ($fell(flash_pins_out.ce_n) && flash_pins_out.oe_n &&
                                      state_ff.step == 3'd0 && !$past(ready_busy_in) &&
                                      !$past(state_ff.win_open) |->
                                      state_ff.cmd == CMD_SUSPEND)
        else $error("command written while flash busy");
    AST_READ_ANSWER: assert property (avs_read_in && avs_waitrequest_out |=>
                                      !avs_waitrequest_out)
        else $error("register read not answered in one cycle");
    AST_SECURE_EXIT: assert property (state_ff.st == ST_WR_HIGH && last_step &&
                                      state_ff.cmd == CMD_SECURE_EXIT |=>
                                      !state_ff.secure)
        else $error("secure mode not left after exit sequence");

endmodule // flash_host

// ### flash_host_pkg.sv
// Constants, types and register map of the NOR flash command host
package flash_host_pkg;

    // Flash bus widths
    localparam int FLASH_AW = 20;
    localparam int FLASH_DW = 16;

    // Avalon register byte offsets
    localparam logic [4:0] OFS_ADDR   = 5'h00;
    localparam logic [4:0] OFS_DATA   = 5'h04;
    localparam logic [4:0] OFS_CTRL   = 5'h08;
    localparam logic [4:0] OFS_CMD    = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_RDATA  = 5'h14;

    // Field positions
    localparam int CTRL_BYTE_BIT    = 0;
    localparam int ST_BUSY_BIT      = 0;
    localparam int ST_RDY_BIT       = 1;
    localparam int ST_BYPASS_BIT    = 2;
    localparam int ST_SECURE_BIT    = 3;
    localparam int ST_WINDOW_BIT    = 4;
    localparam int ST_REFUSED_BIT   = 5;
    localparam int ST_TOGGLED_BIT   = 6;
    localparam int DATA_POLL_BIT    = 7;
    localparam int TOGGLE_BIT       = 6;
    localparam int TIME_LIMIT_BIT   = 5;
    localparam int ERASE_TIMER_BIT  = 3;
    localparam int ERASE_TOGGLE_BIT = 2;

    // Reset values
    localparam logic [FLASH_DW-1:0] RST_DATA = 16'h0000;
    localparam logic [31:0]         RST_RDAT = 32'h0000_0000;

    // Command sequence addresses and codes
    localparam logic [FLASH_AW-1:0] UNLOCK_A1  = 20'h00555;
    localparam logic [FLASH_AW-1:0] UNLOCK_A2  = 20'h002aa;
    localparam logic [FLASH_DW-1:0] UNLOCK_D1  = 16'h00aa;
    localparam logic [FLASH_DW-1:0] UNLOCK_D2  = 16'h0055;
    localparam logic [FLASH_DW-1:0] CODE_PROG  = 16'h00a0;
    localparam logic [FLASH_DW-1:0] CODE_BYP   = 16'h0020;
    localparam logic [FLASH_DW-1:0] CODE_X90   = 16'h0090;
    localparam logic [FLASH_DW-1:0] CODE_RESET = 16'h00f0;
    localparam logic [FLASH_DW-1:0] CODE_ERASE = 16'h0080;
    localparam logic [FLASH_DW-1:0] CODE_CHIP  = 16'h0010;
    localparam logic [FLASH_DW-1:0] CODE_SEC_IN  = 16'h0088;
    localparam logic [FLASH_DW-1:0] CODE_SEC_OUT = 16'h0000;

    // Timing
    localparam int CLK_NS      = 50;
    localparam int WE_LOW_NS   = 100;
    localparam int READ_NS     = 100;
    localparam int RST_LOW_NS  = 500;
    localparam int RST_REC_NS  = 1000;
    localparam int WINDOW_US   = 50;
    localparam logic [15:0] WE_LOW_CYC  = 16'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] READ_CYC    = 16'((READ_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RST_LOW_CYC = 16'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RST_ALL_CYC = 16'((RST_LOW_NS + RST_REC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] WINDOW_CYC  = 16'((WINDOW_US * 1000) / CLK_NS);
    // Setup cycle, strobe low, one spare cycle
    localparam logic [15:0] ADD_SPAN_CYC = 16'h0001 + WE_LOW_CYC + 16'h0001;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_READ, CMD_PROGRAM, CMD_BYP_ENTER, CMD_BYP_PROGRAM, CMD_BYP_EXIT,
        CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_SECTOR_ADD, CMD_SUSPEND, CMD_RESET,
        CMD_SECURE_ENTER, CMD_SECURE_EXIT, CMD_HW_RESET
    } cmd_e;

    typedef enum logic [2:0] {ST_IDLE, ST_WR_SETUP, ST_WR_LOW, ST_WR_HIGH, ST_RD, ST_RST} seq_e;

    typedef struct packed {
        logic [FLASH_AW-1:0] addr;
        logic [FLASH_DW-1:0] dq;
        logic                dq_oe;
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic                rst_n;
        logic                byte_n;
    } flash_pins_s;

    typedef struct packed {
        logic [FLASH_AW-1:0] addr;
        logic [FLASH_DW-1:0] data;
        logic                last;
    } step_s;

endpackage

// ### flash_program_erase_commands_tb_top.sv
// Self-checking bench for the flash command host against the device model
`timescale 1ns/1ps
module flash_program_erase_commands_tb_top;
    import flash_host_pkg::*;
    typedef struct {logic [3:0] cmd; int steps; logic [15:0] last; logic [3:0] st;} row_s;
    logic        clk_in = 1'b0, srst_in = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, ready_busy;
    logic [15:0] dq;
    flash_pins_s pins;
    int          mismatches = 0, compares = 0, base;
    // Status nibble is refused, window, secure, bypass
    row_s rows [12] = '{'{4'hb, 3, CODE_SEC_IN, 4'h2}, '{4'h3, 0, CODE_SEC_IN, 4'ha},
        '{4'hc, 4, CODE_SEC_OUT, 4'h0}, '{4'h3, 3, CODE_BYP, 4'h1}, '{4'h6, 0, CODE_BYP, 4'h9},
        '{4'h4, 2, 16'h0ff0, 4'h1}, '{4'h5, 2, CODE_RESET, 4'h0}, '{4'h6, 6, CODE_CHIP, 4'h0},
        '{4'h7, 6, 16'h0030, 4'h4}, '{4'h8, 1, 16'h0030, 4'h4}, '{4'ha, 1, CODE_RESET, 4'h0},
        '{4'h0, 0, CODE_RESET, 4'h8}};
    always #25 clk_in = ~clk_in;
    flash_host flash_host_inst (.clk_in(clk_in), .srst_in(srst_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
        .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest), .flash_pins_out(pins), .flash_dq_in(dq),
        .ready_busy_in(ready_busy));
    flash_dev_model flash_dev_model_inst (.pins_in(pins), .dq_out(dq),
        .ready_busy_out(ready_busy));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Waitrequest and read data are taken at the rising edge, ahead of the design's update
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_in);
            n++;
            if (n > 3000) begin
                mismatches++;
                close_out();
            end
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_in);
    endtask
    // Without need_rdy only the sequencer has to be idle; the flash may still be busy
    task automatic settle(input logic need_rdy = 1'b1);
        int n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
            if (n > 300) begin
                mismatches++;
                close_out();
            end
        end while (q[ST_BUSY_BIT] !== 1'b0 || (need_rdy && q[ST_RDY_BIT] !== 1'b1));
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        bus(1'b1, OFS_DATA, 32'h0ff0);
        foreach (rows[i]) begin
            base = flash_dev_model_inst.wr_count;
            bus(1'b1, OFS_CMD, {28'h0, rows[i].cmd});
            settle();
            check("steps", 32'(flash_dev_model_inst.wr_count - base), 32'(rows[i].steps));
            check("last data", {16'h0, flash_dev_model_inst.last_ff}, {16'h0, rows[i].last});
            check("status", {28'h0, q[5:2]}, {28'h0, rows[i].st});
            bus(1'b1, OFS_STATUS, 32'h20);
        end
        bus(1'b1, OFS_CMD, 32'h2);
        settle();
        bus(1'b1, OFS_DATA, 32'hff00);
        bus(1'b1, OFS_CMD, 32'h2);
        settle();
        bus(1'b1, OFS_CMD, 32'h1);
        settle();
        bus(1'b0, OFS_RDATA, 32'h0);
        check("read back", q, 32'h0f00);
        bus(1'b1, OFS_CMD, 32'h2);
        settle(1'b0);
        base = flash_dev_model_inst.wr_count;
        bus(1'b1, OFS_CMD, 32'ha);
        check("busy write", 32'(flash_dev_model_inst.wr_count - base), 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("busy refused", {31'h0, q[ST_REFUSED_BIT]}, 32'h1);
        bus(1'b1, OFS_CMD, 32'h9);
        settle(1'b0);
        check("suspend data", {16'h0, flash_dev_model_inst.last_ff}, 32'h00b0);
        check("busy before abort", {31'h0, ready_busy}, 32'h0);
        bus(1'b1, OFS_CMD, 32'hd);
        repeat (15) @(posedge clk_in);
        check("abort", {31'h0, ready_busy}, 32'h1);
        bus(1'b1, OFS_CTRL, 32'h1);
        @(posedge clk_in);
        check("byte pin", {31'h0, pins.byte_n}, 32'h0);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        check("reset pins", {31'h0, pins.ce_n & pins.we_n & pins.rst_n & pins.byte_n}, 32'h1);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("reset status", {27'h0, q[6:2]}, 32'h0);
        close_out();
    end
endmodule // flash_program_erase_commands_tb_top
